/* File: rtl/dmba_pkg.sv */
// What this block does
// - Access bank: top 160 of bank 15, bottom 96 of bank 0
// - Instruction access bit picks bank_select or access bank
// - Access bit 0: low area runs into high area
// - Sixteen banks; direct addressing uses bank_select
// - Address bits 11:8 come from bank_select bits 3:0
// - bank_select bits 7:4 read zero, writes ignored
// - Unimplemented bank: reads give zero, writes dropped
// - Status flags still update on unimplemented banks
// - Each bank has 256 bytes, 8-bit offset
// - move_file_to_file uses full addresses, ignores bank_select
// - load_bank_literal loads bank_select from a literal
package dmba_pkg;

    localparam int unsigned ADDR_W = 12;
    localparam int unsigned OFFS_W = 8;
    localparam int unsigned BANK_W = 4;
    localparam int unsigned NUM_BANKS = 16;
    localparam int unsigned AXI_ADDR_W = 8;
    localparam int unsigned CNT_W = 16;

    localparam logic [7:0] ACCESS_LOW_LAST = 8'h5F;
    localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
    localparam logic [11:0] BANK_SEL_ADDR = 12'hFE0;

    localparam logic [7:0] REG_BANK_SEL = 8'h00;
    localparam logic [7:0] REG_BANK_IMPL = 8'h04;
    localparam logic [7:0] REG_LAST_ACCESS = 8'h08;
    localparam logic [7:0] REG_DROP_COUNT = 8'h0C;

    localparam logic [3:0] BANK_SEL_RST = 4'h0;
    localparam logic [15:0] BANK_IMPL_RST = 16'hFFFF;
    localparam int unsigned LAST_UNIMPL_BIT = 12;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_LOAD_BANK, OP_MOVE_FF} dmba_op_kind_t;

    typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_MOVE} dmba_state_t;

    typedef struct packed {
        dmba_op_kind_t kind;
        logic access_sel;
        logic [7:0] offset;
        logic [7:0] literal;
        logic [11:0] src_addr;
        logic [11:0] dst_addr;
        logic [7:0] wdata;
        logic affects_status;
    } dmba_op_t;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
        logic flags_update;
        logic zero;
        logic [11:0] addr;
        logic unimpl;
    } dmba_result_t;

endpackage

/* File: rtl/dmba_addr_form.sv */
`timescale 1ns/1ps
module dmba_addr_form (
    input wire logic access_sel,
    input wire logic [3:0] bank,
    input wire logic [7:0] offset,
    output logic [11:0] addr
);
    always_comb
    begin
        if (access_sel)
        begin
            addr = {bank, offset};
        end
        else if (offset <= dmba_pkg::ACCESS_LOW_LAST)
        begin
            addr = {dmba_pkg::ACCESS_LOW_BANK, offset};
        end
        else
        begin
            // Offset 60h lands directly after 05Fh in the access view
            addr = {dmba_pkg::ACCESS_HIGH_BANK, offset};
        end
    end
endmodule

/* File: rtl/dmba_data_ram.sv */
`timescale 1ns/1ps
module dmba_data_ram (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic we,
    input wire logic [11:0] addr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata
);
    logic [7:0] mem [0:4095];

    // Sixteen banks of 256 bytes, one flat array
    always_ff @(posedge aclk)
    begin
        if (we)
        begin
            mem[addr] <= wdata;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rdata <= 8'h00;
        end
        else
        begin
            rdata <= mem[addr];
        end
    end
endmodule

/* File: rtl/dmba_top.sv */
// Design decisions made here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
module dmba_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic op_valid,
    output logic op_ready,
    input wire dmba_pkg::dmba_op_t op,
    output dmba_pkg::dmba_result_t res,
    output logic [3:0] bank_select,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready
);
    typedef struct packed {
        dmba_pkg::dmba_state_t st;
        logic [3:0] bank;
        logic [15:0] impl;
        logic [11:0] addr;
        logic src_bank;
        logic src_impl;
        logic upd;
        logic [11:0] last_addr;
        logic last_unimpl;
        logic [15:0] drop_cnt;
        logic [15:0] zread_cnt;
        dmba_pkg::dmba_result_t res;
        logic aw_got;
        logic [7:0] aw_addr;
        logic w_got;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } dmba_regs_t;

    dmba_regs_t r_r;
    dmba_regs_t r_nxt;

    logic [11:0] direct_addr;
    logic [11:0] op_addr;
    logic [11:0] ram_addr;
    logic ram_we;
    logic [7:0] ram_wdata;
    logic [7:0] ram_rdata;
    logic [7:0] move_data;
    logic op_fire;

    dmba_addr_form dmba_addr_form_inst (
        .access_sel(op.access_sel),
        .bank(r_r.bank),
        .offset(op.offset),
        .addr(direct_addr)
    );

    dmba_data_ram dmba_data_ram_inst (
        .aclk(aclk),
        .aresetn(aresetn),
        .we(ram_we),
        .addr(ram_addr),
        .wdata(ram_wdata),
        .rdata(ram_rdata)
    );

    // Only one operation in flight, so the core waits out reads and moves
    assign op_ready = (r_r.st == dmba_pkg::ST_IDLE);
    assign op_fire = op_valid && op_ready;
    assign res = r_r.res;
    assign bank_select = r_r.bank;
    assign awready = !r_r.aw_got && !r_r.bvalid;
    assign wready = !r_r.w_got && !r_r.bvalid;
    assign bvalid = r_r.bvalid;
    assign bresp = r_r.bresp;
    assign arready = !r_r.rvalid;
    assign rvalid = r_r.rvalid;
    assign rdata = r_r.rdata;
    assign rresp = r_r.rresp;

    function automatic logic [15:0] sat_inc(input logic [15:0] v);
        sat_inc = (v == 16'hFFFF) ? v : v + 16'h0001;
    endfunction

    function automatic logic [31:0] reg_read(input dmba_regs_t s, input logic [7:0] a);
        logic [31:0] v;
        v = 32'h0000_0000;
        case (a[7:2])
            dmba_pkg::REG_BANK_SEL[7:2]:
            begin
                v = {28'h000_0000, s.bank};
            end
            dmba_pkg::REG_BANK_IMPL[7:2]:
            begin
                v = {16'h0000, s.impl};
            end
            dmba_pkg::REG_LAST_ACCESS[7:2]:
            begin
                v = {19'h0_0000, s.last_unimpl, s.last_addr};
            end
            dmba_pkg::REG_DROP_COUNT[7:2]:
            begin
                v = {s.zread_cnt, s.drop_cnt};
            end
            default:
            begin
                v = 32'h0000_0000;
            end
        endcase
        reg_read = v;
    endfunction

    function automatic logic reg_mapped(input logic [7:0] a);
        reg_mapped = (a[7:2] == dmba_pkg::REG_BANK_SEL[7:2])
            || (a[7:2] == dmba_pkg::REG_BANK_IMPL[7:2])
            || (a[7:2] == dmba_pkg::REG_LAST_ACCESS[7:2])
            || (a[7:2] == dmba_pkg::REG_DROP_COUNT[7:2]);
    endfunction

    always_comb
    begin
        r_nxt = r_r;
        r_nxt.res.valid = 1'b0;
        op_addr = (op.kind == dmba_pkg::OP_MOVE_FF) ? op.src_addr : direct_addr;
        move_data = r_r.src_bank ? {4'h0, r_r.bank} : (r_r.src_impl ? ram_rdata : 8'h00);
        ram_addr = op_addr;
        ram_we = 1'b0;
        ram_wdata = op.wdata;

        // Register bus: write address and data may come in either order
        if (awvalid && awready)
        begin
            r_nxt.aw_got = 1'b1;
            r_nxt.aw_addr = awaddr;
        end
        if (wvalid && wready)
        begin
            r_nxt.w_got = 1'b1;
            r_nxt.w_data = wdata;
            r_nxt.w_strb = wstrb;
        end
        if (r_r.aw_got && r_r.w_got && !r_r.bvalid)
        begin
            r_nxt.aw_got = 1'b0;
            r_nxt.w_got = 1'b0;
            r_nxt.bvalid = 1'b1;
            r_nxt.bresp = reg_mapped(r_r.aw_addr) ? dmba_pkg::RESP_OKAY : dmba_pkg::RESP_DECERR;
            case (r_r.aw_addr[7:2])
                dmba_pkg::REG_BANK_SEL[7:2]:
                begin
                    if (r_r.w_strb[0])
                    begin
                        r_nxt.bank = r_r.w_data[3:0];
                    end
                end
                dmba_pkg::REG_BANK_IMPL[7:2]:
                begin
                    if (r_r.w_strb[0])
                    begin
                        r_nxt.impl[7:0] = r_r.w_data[7:0];
                    end
                    if (r_r.w_strb[1])
                    begin
                        r_nxt.impl[15:8] = r_r.w_data[15:8];
                    end
                end
                dmba_pkg::REG_DROP_COUNT[7:2]:
                begin
                    // Any write to a half clears that counter
                    if (|r_r.w_strb[1:0])
                    begin
                        r_nxt.drop_cnt = 16'h0000;
                    end
                    if (|r_r.w_strb[3:2])
                    begin
                        r_nxt.zread_cnt = 16'h0000;
                    end
                end
                default:
                begin
                end
            endcase
        end
        if (r_r.bvalid && bready)
        begin
            r_nxt.bvalid = 1'b0;
        end
        if (arvalid && arready)
        begin
            r_nxt.rvalid = 1'b1;
            r_nxt.rdata = reg_read(r_r, araddr);
            r_nxt.rresp = reg_mapped(araddr) ? dmba_pkg::RESP_OKAY : dmba_pkg::RESP_DECERR;
        end
        if (r_r.rvalid && rready)
        begin
            r_nxt.rvalid = 1'b0;
        end

        // Core side runs after the bus so an instruction wins a bank_select race
        case (r_r.st)
            dmba_pkg::ST_IDLE:
            begin
                if (op_fire)
                begin
                    r_nxt.src_bank = (op_addr == dmba_pkg::BANK_SEL_ADDR);
                    r_nxt.src_impl = r_r.impl[op_addr[11:8]];
                    r_nxt.upd = op.affects_status;
                    r_nxt.addr = op_addr;
                    case (op.kind)
                        dmba_pkg::OP_READ:
                        begin
                            r_nxt.st = dmba_pkg::ST_READ;
                        end
                        dmba_pkg::OP_WRITE:
                        begin
                            if (op_addr == dmba_pkg::BANK_SEL_ADDR)
                            begin
                                r_nxt.bank = op.wdata[3:0];
                            end
                            else
                            begin
                                ram_we = r_r.impl[op_addr[11:8]];
                            end
                            r_nxt.res.valid = 1'b1;
                            r_nxt.res.data = op.wdata;
                            r_nxt.res.flags_update = op.affects_status;
                            r_nxt.res.zero = (op.wdata == 8'h00);
                            r_nxt.res.addr = op_addr;
                            r_nxt.res.unimpl = !r_r.impl[op_addr[11:8]]
                                && (op_addr != dmba_pkg::BANK_SEL_ADDR);
                            r_nxt.last_addr = op_addr;
                            r_nxt.last_unimpl = r_nxt.res.unimpl;
                            if (r_nxt.res.unimpl)
                            begin
                                r_nxt.drop_cnt = sat_inc(r_nxt.drop_cnt);
                            end
                        end
                        dmba_pkg::OP_LOAD_BANK:
                        begin
                            r_nxt.bank = op.literal[3:0];
                            r_nxt.res.valid = 1'b1;
                            r_nxt.res.data = {4'h0, op.literal[3:0]};
                            r_nxt.res.flags_update = 1'b0;
                            r_nxt.res.zero = 1'b0;
                            r_nxt.res.addr = dmba_pkg::BANK_SEL_ADDR;
                            r_nxt.res.unimpl = 1'b0;
                        end
                        default:
                        begin
                            // Source read now, destination written next cycle
                            r_nxt.addr = op.dst_addr;
                            r_nxt.st = dmba_pkg::ST_MOVE;
                        end
                    endcase
                end
            end
            dmba_pkg::ST_READ:
            begin
                r_nxt.st = dmba_pkg::ST_IDLE;
                r_nxt.res.valid = 1'b1;
                r_nxt.res.data = move_data;
                r_nxt.res.flags_update = r_r.upd;
                r_nxt.res.zero = (move_data == 8'h00);
                r_nxt.res.addr = r_r.addr;
                r_nxt.res.unimpl = !r_r.src_impl && !r_r.src_bank;
                r_nxt.last_addr = r_r.addr;
                r_nxt.last_unimpl = r_nxt.res.unimpl;
                if (r_nxt.res.unimpl)
                begin
                    r_nxt.zread_cnt = sat_inc(r_nxt.zread_cnt);
                end
            end
            dmba_pkg::ST_MOVE:
            begin
                r_nxt.st = dmba_pkg::ST_IDLE;
                ram_addr = r_r.addr;
                ram_wdata = move_data;
                if (r_r.addr == dmba_pkg::BANK_SEL_ADDR)
                begin
                    r_nxt.bank = move_data[3:0];
                end
                else
                begin
                    ram_we = r_r.impl[r_r.addr[11:8]];
                end
                r_nxt.res.valid = 1'b1;
                r_nxt.res.data = move_data;
                r_nxt.res.flags_update = 1'b0;
                r_nxt.res.zero = (move_data == 8'h00);
                r_nxt.res.addr = r_r.addr;
                r_nxt.res.unimpl = !r_r.impl[r_r.addr[11:8]]
                    && (r_r.addr != dmba_pkg::BANK_SEL_ADDR);
                r_nxt.last_addr = r_r.addr;
                r_nxt.last_unimpl = r_nxt.res.unimpl;
                if (!r_r.src_impl && !r_r.src_bank)
                begin
                    r_nxt.zread_cnt = sat_inc(r_nxt.zread_cnt);
                end
                if (r_nxt.res.unimpl)
                begin
                    r_nxt.drop_cnt = sat_inc(r_nxt.drop_cnt);
                end
            end
            default:
            begin
                r_nxt.st = dmba_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            r_r <= '0;
            r_r.st <= dmba_pkg::ST_IDLE;
            r_r.bank <= dmba_pkg::BANK_SEL_RST;
            r_r.impl <= dmba_pkg::BANK_IMPL_RST;
        end
        else
        begin
            r_r <= r_nxt;
        end
    end
endmodule

/* File: test/dmba_asserts.sv */
`timescale 1ns/1ps
module dmba_asserts (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic op_valid,
    input wire logic op_ready,
    input wire dmba_pkg::dmba_op_t op,
    input wire dmba_pkg::dmba_result_t res,
    input wire logic [3:0] bank_select
);
    logic take;
    logic rd;
    logic [3:0] lit_lo;
    assign take = op_valid && op_ready;
    assign rd = take && op.kind == dmba_pkg::OP_READ;
    assign lit_lo = op.literal[3:0];
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    chk_bank_direct:
    assert property (rd && op.access_sel |-> ##2 res.valid
        && res.addr == {$past(bank_select, 2), $past(op.offset, 2)})
        else $error("direct address wrong");
    chk_access_low:
    assert property (rd && !op.access_sel && op.offset <= 8'h5F
        |-> ##2 res.addr == {4'h0, $past(op.offset, 2)})
        else $error("access low address wrong");
    chk_access_high:
    assert property (rd && !op.access_sel && op.offset > 8'h5F
        |-> ##2 res.addr == {4'hF, $past(op.offset, 2)})
        else $error("access high address wrong");
    chk_write_flags:
    assert property (take && op.kind == dmba_pkg::OP_WRITE
        |=> res.valid && res.flags_update == $past(op.affects_status))
        else $error("write result wrong");
    chk_load_bank:
    assert property (take && op.kind == dmba_pkg::OP_LOAD_BANK |=> bank_select == $past(lit_lo))
        else $error("bank load wrong");
    chk_move_flow:
    assert property (take && op.kind == dmba_pkg::OP_MOVE_FF
        |=> !op_ready ##1 res.valid && !res.flags_update)
        else $error("move sequence wrong");
    chk_unimpl_zero:
    assert property (rd |-> ##2 !res.unimpl || (res.data == 8'h00 && res.zero))
        else $error("unimplemented read not zero");
    chk_bank_upper:
    assert property (rd && !op.access_sel && op.offset == 8'hE0
        |-> ##2 res.data == {4'h0, $past(bank_select, 2)})
        else $error("bank select read wrong");
endmodule

bind dmba_top dmba_asserts dmba_asserts_inst (.aclk, .aresetn, .op_valid, .op_ready, .op,
    .res, .bank_select);

/* File: test/dmba_core_model.sv */
`timescale 1ns/1ps
module dmba_core_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic go,
    input wire dmba_pkg::dmba_op_t cmd,
    input wire logic op_ready,
    output logic op_valid,
    output dmba_pkg::dmba_op_t op
);
    // Released payload is inverted so a stale value never looks valid
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            op_valid <= 1'b0;
            op <= '0;
        end
        else if (go)
        begin
            op_valid <= 1'b1;
            op <= cmd;
        end
        else if (op_valid && op_ready)
        begin
            op_valid <= 1'b0;
            op <= ~op;
        end
    end
endmodule

/* File: test/testbench.sv */
`timescale 1ns/1ps
module testbench;
    logic aclk, aresetn, go, op_valid, op_ready, awvalid, awready, wvalid, wready;
    logic bvalid, bready, arvalid, arready, rvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb, bank_select;
    logic [1:0] bresp, rresp, r, wr;
    dmba_pkg::dmba_op_t cmd, op;
    dmba_pkg::dmba_result_t res, rs;
    int failures, checked;

    initial
    begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    dmba_core_model dmba_core_model_inst (.aclk, .aresetn, .go, .cmd, .op_ready, .op_valid, .op);
    dmba_top dmba_top_inst (.aclk, .aresetn, .op_valid, .op_ready, .op, .res, .bank_select,
        .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
        .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);

    task cmp(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            failures++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask

    task core(input dmba_pkg::dmba_op_kind_t k, input logic [7:0] v, input logic a = 1'b0,
        input logic [7:0] o = 8'h00, input logic [11:0] s = 12'h000, input logic [11:0] t = 12'h000,
        input logic f = 1'b1);
        int i;
        @(posedge aclk);
        cmd <= '{kind: k, access_sel: a, offset: o, literal: v, src_addr: s, dst_addr: t,
            wdata: v, affects_status: f};
        go <= 1'b1;
        @(posedge aclk);
        go <= 1'b0;
        for (i = 0; i < 20 && res.valid !== 1'b1; i++)
            @(negedge aclk);
        rs = res;
        cmp("core answer", 32'h1, {31'h0, i < 20});
    endtask

    task axi_write(input logic [7:0] a, input logic [31:0] v);
        logic aw, w, b;
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        b = 1'b0;
        // Waits for the answer however long it takes; only the watchdog ends a hang
        while (!b)
        begin
            @(negedge aclk);
            aw = awvalid && awready;
            w = wvalid && wready;
            b = (bvalid === 1'b1);
            wr = bresp;
            @(posedge aclk);
            if (aw)
                awvalid <= 1'b0;
            if (w)
                wvalid <= 1'b0;
        end
        bready <= 1'b0;
    endtask

    task axi_read(input logic [7:0] a);
        logic ar, b;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        b = 1'b0;
        while (!b)
        begin
            @(negedge aclk);
            ar = arvalid && arready;
            b = (rvalid === 1'b1);
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (ar)
                arvalid <= 1'b0;
        end
        rready <= 1'b0;
    endtask

    task t_access;
        core(dmba_pkg::OP_WRITE, 8'h11, 1'b0, 8'h5F);
        cmp("low address", 32'h05F, rs.addr);
        core(dmba_pkg::OP_WRITE, 8'h22, 1'b0, 8'h60);
        cmp("high address", 32'hF60, rs.addr);
        core(dmba_pkg::OP_LOAD_BANK, 8'h00);
        core(dmba_pkg::OP_READ, 8'h00, 1'b1, 8'h5F);
        cmp("bank 0 data", 32'h11, rs.data);
        core(dmba_pkg::OP_LOAD_BANK, 8'h0F);
        core(dmba_pkg::OP_READ, 8'h00, 1'b1, 8'h60);
        cmp("bank 15 data", 32'h22, rs.data);
        cmp("bank 15 address", 32'hF60, rs.addr);
        $display("test access done");
    endtask

    task t_bank_reg;
        core(dmba_pkg::OP_LOAD_BANK, 8'hA7);
        cmp("bank_select", 32'h7, bank_select);
        core(dmba_pkg::OP_READ, 8'h00, 1'b0, 8'hE0);
        cmp("bank_select read", 32'h07, rs.data);
        axi_write(dmba_pkg::REG_BANK_SEL, 32'hFFFFFFF3);
        cmp("bank_select write resp", dmba_pkg::RESP_OKAY, wr);
        axi_read(dmba_pkg::REG_BANK_SEL);
        cmp("bank_select bus", 32'h3, d);
        cmp("bank_select port", 32'h3, bank_select);
        $display("test bank register done");
    endtask

    task t_unimpl;
        axi_write(dmba_pkg::REG_BANK_IMPL, 32'h0000FFF7);
        core(dmba_pkg::OP_LOAD_BANK, 8'h03);
        core(dmba_pkg::OP_WRITE, 8'h55, 1'b1, 8'hFF);
        cmp("write unimpl", 32'h1, rs.unimpl);
        cmp("flags update", 32'h1, rs.flags_update);
        core(dmba_pkg::OP_READ, 8'h00, 1'b1, 8'hFF);
        cmp("unimpl data", 32'h0, rs.data);
        cmp("zero flag", 32'h1, rs.zero);
        core(dmba_pkg::OP_READ, 8'h00, 1'b1, 8'hFF, 12'h000, 12'h000, 1'b0);
        cmp("no flags update", 32'h0, rs.flags_update);
        cmp("unimpl read flag", 32'h1, rs.unimpl);
        axi_read(dmba_pkg::REG_DROP_COUNT);
        cmp("dropped writes", 32'h1, d[15:0]);
        cmp("zero reads", 32'h2, d[31:16]);
        axi_read(dmba_pkg::REG_LAST_ACCESS);
        cmp("last access", 32'h0000_13FF, d);
        axi_write(dmba_pkg::REG_BANK_IMPL, 32'h0000FFFF);
        $display("test unimplemented bank done");
    endtask

    task t_move;
        core(dmba_pkg::OP_LOAD_BANK, 8'h02);
        core(dmba_pkg::OP_WRITE, 8'h3C, 1'b1, 8'h10);
        core(dmba_pkg::OP_LOAD_BANK, 8'h0F);
        core(dmba_pkg::OP_MOVE_FF, 8'h00, 1'b1, 8'h00, 12'h210, 12'h4A5);
        cmp("move flags", 32'h0, rs.flags_update);
        core(dmba_pkg::OP_LOAD_BANK, 8'h04);
        core(dmba_pkg::OP_READ, 8'h00, 1'b1, 8'hA5);
        cmp("moved data", 32'h3C, rs.data);
        axi_read(8'h40);
        cmp("unmapped resp", dmba_pkg::RESP_DECERR, r);
        cmp("unmapped data", 32'h0, d);
        axi_write(8'h40, 32'h0000_0001);
        cmp("unmapped write resp", dmba_pkg::RESP_DECERR, wr);
        axi_read(dmba_pkg::REG_BANK_SEL);
        cmp("bank after unmapped", 32'h4, d);
        $display("test move and unmapped done");
    endtask

    task end_of_test;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial
    begin
        #400000;
        failures++;
        end_of_test;
    end

    initial
    begin
        failures = 0;
        checked = 0;
        {aresetn, go, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, wstrb} = '0;
        cmd = '0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        axi_read(dmba_pkg::REG_BANK_IMPL);
        cmp("mask reset", 32'h0000FFFF, d);
        cmp("bank reset", 32'h0, bank_select);
        t_access;
        t_bank_reg;
        t_unimpl;
        t_move;
        end_of_test;
    end
endmodule
